// file: shared/gcsr_defs.svh
// Offsets, field positions, reset values and timing counts of the global registers.
// What this block does
// - Enable bit lets bus pin interrupts report.
// - Timer clock: local clock or frame sync.
// - Serial select turns upper pins serial.
// - DMA select turns lower pins DMA.
// - After reset: bus mode, all inputs.
// - Terminal mode only at 2/4 Mbit.
// - Local clock divides by 1,2,4,16.
// - Burst enable honoured only with demux high.
// - Byte order bit swaps data only.
// - Timer period is reload plus two.
// - Run bit loads counter or stops it.
// - Local request starts, clears on outcome.
// - PCM request starts, clears on outcome.
// - Events set flags, unmasked raise interrupt.
// - Upper flags mark queue entries written.
// - Timer underflow sets timer flag.
// - Frame pulse mismatch sets async flags.
// - Requests report fail or acknowledge.
// - Lower flags have no queue entry.
// - Writing one acknowledges and clears flag.
// - Masked events set flag only.
`ifndef GCSR_DEFS_SVH
`define GCSR_DEFS_SVH

`define GCSR_OFS_GLOBAL_CONFIGURATION     8'h00
`define GCSR_OFS_CMD      8'h04
`define GCSR_OFS_STAT     8'h08
`define GCSR_OFS_MASK     8'h0c

`define GCSR_GLOBAL_CONFIGURATION_RESET   32'h00000000
`define GCSR_MASK_RESET   16'hff7f
`define GCSR_STAT_USED    16'hff7f

`define GCSR_GLOBAL_CONFIGURATION_LBE     0
`define GCSR_GLOBAL_CONFIGURATION_DBE     1
`define GCSR_GLOBAL_CONFIGURATION_LCD_LO  2
`define GCSR_GLOBAL_CONFIGURATION_IOM     4
`define GCSR_GLOBAL_CONFIGURATION_LBI     5
`define GCSR_GLOBAL_CONFIGURATION_SSC     6
`define GCSR_GLOBAL_CONFIGURATION_GPBUS_IRQ_ENABLE    7
`define GCSR_GLOBAL_CONFIGURATION_CST     8
`define GCSR_GLOBAL_CONFIGURATION_BITS    9

`define GCSR_CMD_PCM_ACTION_REQUEST    0
`define GCSR_CMD_ARLB     1
`define GCSR_CMD_TIMER_RUN     4
`define GCSR_CMD_TIMER_RELOAD_VALUE_LO  16

`define GCSR_ST_PCM_REQUEST_ACK      0
`define GCSR_ST_PCM_REQUEST_FAIL      1
`define GCSR_ST_LBA       2
`define GCSR_ST_LBF       3
`define GCSR_ST_RSA       4
`define GCSR_ST_TSA       5
`define GCSR_ST_TI        6
`define GCSR_ST_QUEUE_LO  8

`define GCSR_DIV2_LAST    4'd1
`define GCSR_DIV4_LAST    4'd3
`define GCSR_DIV16_LAST   4'd15

`endif

// file: shared/gcsr_pkg.sv
// Types shared by the global control and status register block.
package gcsr_pkg;
	typedef logic [31:0] gcsr_word_t;
	typedef logic [15:0] gcsr_half_t;
	typedef logic [7:0]  gcsr_addr_t;
	// Local clock division settings, in the order of their two-bit code.
	typedef enum logic [1:0] {
		GCSR_DIV1,
		GCSR_DIV2,
		GCSR_DIV4,
		GCSR_DIV16
	} gcsr_div_e;
endpackage : gcsr_pkg

// file: shared/gcsr_tmr_if.sv
// Interface between the register block and its periodic down-count timer.
`timescale 1ns/1ps
`default_nettype none
interface gcsr_tmr_if;
	import gcsr_pkg::*;
	gcsr_half_t reload;
	logic       load;
	logic       stop;
	logic       tick;
	logic       underflow;
	logic       running;
	modport ctrl (output reload, output load, output stop, output tick,
		input underflow, input running);
	modport tmr (input reload, input load, input stop, input tick,
		output underflow, output running);
endinterface : gcsr_tmr_if
`default_nettype wire

// file: rtl/gcsr_timer.sv
// Periodic down-count timer with reload.
`timescale 1ns/1ps
`default_nettype none
`include "gcsr_defs.svh"
module gcsr_timer (
	input  wire logic clk,
	input  wire logic rst,
	gcsr_tmr_if.tmr   t
);
	import gcsr_pkg::*;

	logic [16:0] count;
	logic        run;
	logic        uf;

	// Load reload plus one so that counting down through zero spans reload plus two ticks.
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 17'h00000;
		end else if (t.load) begin
			count <= {1'b0, t.reload} + 17'h00001;
		end else if (run && t.tick) begin
			if (count == 17'h00000) begin
				count <= {1'b0, t.reload} + 17'h00001;
			end else begin
				count <= count - 17'h00001;
			end
		end
	end

	// Run state follows the run bit writes.
	always_ff @(posedge clk) begin
		if (rst) begin
			run <= 1'b0;
		end else if (t.load) begin
			run <= 1'b1;
		end else if (t.stop) begin
			run <= 1'b0;
		end
	end

	// One-cycle pulse on each underflow.
	always_ff @(posedge clk) begin
		if (rst) begin
			uf <= 1'b0;
		end else begin
			uf <= run && t.tick && !t.load && (count == 17'h00000);
		end
	end

	assign t.underflow = uf;
	assign t.running   = run;
endmodule : gcsr_timer
`default_nettype wire

// file: rtl/gcsr_top.sv
// Global configuration, command and event status registers with pin muxing.
`timescale 1ns/1ps
`default_nettype none
`include "gcsr_defs.svh"
module gcsr_top (
	input  wire logic                clk,
	input  wire logic                rst,
	// Register access port, byte addresses.
	input  wire gcsr_pkg::gcsr_addr_t reg_addr,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire gcsr_pkg::gcsr_word_t reg_wdata,
	output logic [31:0]              reg_rdata,
	// Event sources, one-cycle pulses.
	input  wire logic [7:0]          queue_evt,
	input  wire logic                tx_sync_async_evt,
	input  wire logic                rx_sync_async_evt,
	input  wire logic                local_req_fail_evt,
	input  wire logic                local_req_ack_evt,
	input  wire logic                pcm_req_fail_evt,
	input  wire logic                pcm_req_ack_evt,
	input  wire logic                gpbus_evt,
	// Pins and core status.
	input  wire logic                rx_frame_sync_pin,
	input  wire logic                demux_pin,
	input  wire logic                pcm_rate_2_or_4,
	// General purpose bus register values and pins.
	input  wire logic [15:0]         gpbus_direction,
	input  wire logic [15:0]         gpbus_open_drain,
	input  wire logic [15:0]         gpbus_data,
	input  wire logic [15:0]         gp_pin_in,
	output logic [15:0]              gp_pin_out,
	output logic [15:0]              gp_pin_oe,
	output logic [15:0]              gpbus_in,
	// Serial port and DMA functions of the pins.
	input  wire logic                serial_clock,
	input  wire logic                serial_data_out,
	input  wire logic [3:0]          serial_chip_select,
	output logic                     serial_data_in,
	input  wire logic [3:0]          dma_request,
	output logic [3:0]               dma_ack,
	// Configuration outputs and requests.
	output logic                     gpbus_evt_report,
	output logic                     terminal_bus_active,
	output logic                     local_clk_tick,
	output logic                     demux_burst_active,
	output logic                     byte_order_select,
	output logic                     local_action_request,
	output logic                     pcm_action_request,
	output logic [15:0]              event_status_q,
	output logic                     inta_n
);
	import gcsr_pkg::*;

	// Full-width reset word; only the implemented low bits are kept.
	localparam gcsr_word_t global_configuration_reset = `GCSR_GLOBAL_CONFIGURATION_RESET;

	gcsr_tmr_if tif ();

	logic [`GCSR_GLOBAL_CONFIGURATION_BITS-1:0] global_configuration;
	gcsr_half_t                 event_mask;
	gcsr_half_t                 event_status;
	gcsr_half_t                 timer_reload_value;
	gcsr_half_t                 next_status;
	gcsr_half_t                 events;
	gcsr_half_t                 next_pin_out;
	logic [3:0]                 div_count;
	logic [3:0]                 div_last;
	logic                       rsp_q;
	logic                       tmr_tick;
	logic                       wr_global_configuration;
	logic                       wr_cmd;
	logic                       wr_stat;
	logic                       wr_mask;
	logic                       start_local;
	logic                       start_pcm;
	logic                       gpbus_irq_enable;
	logic                       timer_clock_select;
	logic                       ssc_sel;
	logic                       dma_sel;
	gcsr_div_e                  local_clock_divider;

	// Register write decode.
	assign wr_global_configuration = reg_wr && (reg_addr == `GCSR_OFS_GLOBAL_CONFIGURATION);
	assign wr_cmd  = reg_wr && (reg_addr == `GCSR_OFS_CMD);
	assign wr_stat = reg_wr && (reg_addr == `GCSR_OFS_STAT);
	assign wr_mask = reg_wr && (reg_addr == `GCSR_OFS_MASK);

	// Configuration fields.
	assign gpbus_irq_enable    = global_configuration[`GCSR_GLOBAL_CONFIGURATION_GPBUS_IRQ_ENABLE];
	assign timer_clock_select     = global_configuration[`GCSR_GLOBAL_CONFIGURATION_CST];
	assign ssc_sel = global_configuration[`GCSR_GLOBAL_CONFIGURATION_SSC];
	assign dma_sel = global_configuration[`GCSR_GLOBAL_CONFIGURATION_LBI];
	assign local_clock_divider     = gcsr_div_e'(global_configuration[`GCSR_GLOBAL_CONFIGURATION_LCD_LO +: 2]);

	// Configuration register; reset leaves pins in plain bus mode.
	always_ff @(posedge clk) begin
		if (rst) begin
			global_configuration <= global_configuration_reset[`GCSR_GLOBAL_CONFIGURATION_BITS-1:0];
		end else if (wr_global_configuration) begin
			global_configuration <= reg_wdata[`GCSR_GLOBAL_CONFIGURATION_BITS-1:0];
		end
	end

	// Event mask register.
	always_ff @(posedge clk) begin
		if (rst) begin
			event_mask <= `GCSR_MASK_RESET;
		end else if (wr_mask) begin
			event_mask <= reg_wdata[15:0] & `GCSR_STAT_USED;
		end
	end

	// Timer reload value is held from the last command write.
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_reload_value <= 16'h0000;
		end else if (wr_cmd) begin
			timer_reload_value <= reg_wdata[`GCSR_CMD_TIMER_RELOAD_VALUE_LO +: 16];
		end
	end

	// Command bits drive the timer. Auto-reload must use the stored value,
	// since the write data bus carries unrelated words between command writes.
	assign tif.reload = wr_cmd ? reg_wdata[`GCSR_CMD_TIMER_RELOAD_VALUE_LO +: 16] : timer_reload_value;
	assign tif.load   = wr_cmd && reg_wdata[`GCSR_CMD_TIMER_RUN];
	assign tif.stop   = wr_cmd && !reg_wdata[`GCSR_CMD_TIMER_RUN];
	assign tif.tick   = tmr_tick && tif.running;

	gcsr_timer u_timer (
		.clk (clk),
		.rst (rst),
		.t   (tif.tmr)
	);

	// Last division count for each local clock setting.
	always_comb begin
		case (local_clock_divider)
			GCSR_DIV1:  div_last = 4'd0;
			GCSR_DIV2:  div_last = `GCSR_DIV2_LAST;
			GCSR_DIV4:  div_last = `GCSR_DIV4_LAST;
			GCSR_DIV16: div_last = `GCSR_DIV16_LAST;
			default:    div_last = 4'd0;
		endcase
	end

	// Local clock divider issues one tick per divided period.
	always_ff @(posedge clk) begin
		if (rst) begin
			div_count      <= 4'h0;
			local_clk_tick <= 1'b0;
		end else if (div_count >= div_last) begin
			div_count      <= 4'h0;
			local_clk_tick <= 1'b1;
		end else begin
			div_count      <= div_count + 4'h1;
			local_clk_tick <= 1'b0;
		end
	end

	// Frame sync pin edge history for the timer source.
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_q <= 1'b0;
		end else begin
			rsp_q <= rx_frame_sync_pin;
		end
	end

	// Timer ticks come from the local clock or the frame sync rising edge.
	assign tmr_tick = timer_clock_select ? (rx_frame_sync_pin && !rsp_q) : local_clk_tick;

	// Action requests start only if neither is active and end on an outcome.
	assign start_local = wr_cmd && reg_wdata[`GCSR_CMD_ARLB] &&
		!local_action_request && !pcm_action_request;
	assign start_pcm   = wr_cmd && reg_wdata[`GCSR_CMD_PCM_ACTION_REQUEST] &&
		!local_action_request && !pcm_action_request && !start_local;

	always_ff @(posedge clk) begin
		if (rst) begin
			local_action_request <= 1'b0;
		end else if (local_req_fail_evt || local_req_ack_evt) begin
			local_action_request <= 1'b0;
		end else if (start_local) begin
			local_action_request <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pcm_action_request <= 1'b0;
		end else if (pcm_req_fail_evt || pcm_req_ack_evt) begin
			pcm_action_request <= 1'b0;
		end else if (start_pcm) begin
			pcm_action_request <= 1'b1;
		end
	end

	// Collect this cycle's events into status positions.
	always_comb begin
		events = 16'h0000;
		events[`GCSR_ST_QUEUE_LO +: 8] = queue_evt;
		events[`GCSR_ST_TI]   = tif.underflow;
		events[`GCSR_ST_TSA]  = tx_sync_async_evt;
		events[`GCSR_ST_RSA]  = rx_sync_async_evt;
		events[`GCSR_ST_LBF]  = local_req_fail_evt;
		events[`GCSR_ST_LBA]  = local_req_ack_evt;
		events[`GCSR_ST_PCM_REQUEST_FAIL] = pcm_req_fail_evt;
		events[`GCSR_ST_PCM_REQUEST_ACK] = pcm_req_ack_evt;
	end

	// Write-one acknowledge clears a flag, but a new event in that cycle wins.
	always_comb begin
		next_status = event_status;
		if (wr_stat) begin
			next_status = next_status & ~reg_wdata[15:0];
		end
		next_status = (next_status | events) & `GCSR_STAT_USED;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			event_status <= 16'h0000;
		end else begin
			event_status <= next_status;
		end
	end

	// Interrupt line is low while any unmasked flag stands.
	always_ff @(posedge clk) begin
		if (rst) begin
			inta_n <= 1'b1;
		end else begin
			inta_n <= ~|(next_status & ~event_mask);
		end
	end

	// Status copy for other units.
	always_ff @(posedge clk) begin
		if (rst) begin
			event_status_q <= 16'h0000;
		end else begin
			event_status_q <= next_status;
		end
	end

	// Read data, one cycle after the read strobe; command reads as zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`GCSR_OFS_GLOBAL_CONFIGURATION: reg_rdata <= {23'h000000, global_configuration};
				`GCSR_OFS_STAT: reg_rdata <= {16'h0000, event_status};
				`GCSR_OFS_MASK: reg_rdata <= {16'h0000, event_mask};
				default:        reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// Derived mode outputs.
	always_ff @(posedge clk) begin
		if (rst) begin
			gpbus_evt_report    <= 1'b0;
			terminal_bus_active <= 1'b0;
			demux_burst_active  <= 1'b0;
			byte_order_select   <= 1'b0;
		end else begin
			gpbus_evt_report    <= gpbus_evt && gpbus_irq_enable;
			terminal_bus_active <= global_configuration[`GCSR_GLOBAL_CONFIGURATION_IOM] &&
				pcm_rate_2_or_4;
			demux_burst_active  <= global_configuration[`GCSR_GLOBAL_CONFIGURATION_DBE] &&
				demux_pin;
			byte_order_select   <= global_configuration[`GCSR_GLOBAL_CONFIGURATION_LBE];
		end
	end

	// Pin output values, chosen by the serial and DMA function selects.
	always_comb begin
		next_pin_out = gpbus_data;
		if (ssc_sel) begin
			next_pin_out[15:8] = {serial_clock, serial_data_out, 2'b00,
				serial_chip_select[0], serial_chip_select[1],
				serial_chip_select[2], serial_chip_select[3]};
		end
		if (dma_sel) begin
			next_pin_out[7:4] = {dma_request[0], dma_request[1],
				dma_request[2], dma_request[3]};
		end
	end

	// Pin drive. Direction and open drain always come from host settings,
	// also in serial mode, so the host must set them per pin function.
	always_ff @(posedge clk) begin
		if (rst) begin
			gp_pin_out <= 16'h0000;
			gp_pin_oe  <= 16'h0000;
		end else begin
			gp_pin_out <= next_pin_out;
			gp_pin_oe  <= gpbus_direction & (~gpbus_open_drain | ~next_pin_out);
		end
	end

	// Inputs from the pins, split by mode.
	always_ff @(posedge clk) begin
		if (rst) begin
			gpbus_in       <= 16'h0000;
			serial_data_in <= 1'b0;
			dma_ack        <= 4'h0;
		end else begin
			gpbus_in[15:8] <= ssc_sel ? 8'h00 : gp_pin_in[15:8];
			gpbus_in[7:0]  <= dma_sel ? 8'h00 : gp_pin_in[7:0];
			serial_data_in <= ssc_sel && gp_pin_in[13];
			dma_ack        <= dma_sel ? gp_pin_in[3:0] : 4'h0;
		end
	end

endmodule : gcsr_top
`default_nettype wire

// file: dv/gcsr_monitor.sv
// Port-level assertions for the global register block.
`timescale 1ns/1ps
`default_nettype none
module gcsr_monitor (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire gcsr_pkg::gcsr_addr_t reg_addr,
	input wire logic                 reg_wr,
	input wire gcsr_pkg::gcsr_word_t reg_wdata,
	input wire logic [7:0]           queue_evt,
	input wire logic                 local_req_fail_evt,
	input wire logic                 local_req_ack_evt,
	input wire logic                 pcm_req_fail_evt,
	input wire logic                 pcm_req_ack_evt,
	input wire logic                 gpbus_evt,
	input wire logic                 demux_pin,
	input wire logic                 gpbus_evt_report,
	input wire logic                 demux_burst_active,
	input wire logic                 local_action_request,
	input wire logic                 pcm_action_request,
	input wire logic [15:0]          event_status_q,
	input wire logic                 inta_n
);
	import gcsr_pkg::*;
	gcsr_half_t msk;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Shadow of the mask register, rebuilt from the writes seen on the port.
	always_ff @(posedge clk) begin
		if (rst) msk <= 16'hff7f;
		else if (reg_wr && reg_addr == 8'h0c) msk <= reg_wdata[15:0] & 16'hff7f;
	end
	// Flags follow their events and the interrupt line follows unmasked flags.
	stat_set_a: assert property (pcm_req_ack_evt |=> event_status_q[0])
		else $error("pcm ack event did not set its flag");
	queue_flag_a: assert property (queue_evt[7] |=> event_status_q[15])
		else $error("queue event did not set its flag");
	ack_clear_a: assert property (reg_wr && reg_addr == 8'h08 && reg_wdata[2]
		&& !local_req_ack_evt |=> !event_status_q[2]) else $error("ack did not clear flag");
	inta_level_a: assert property ($stable(msk) && $stable(event_status_q)
		|-> inta_n == ((event_status_q & ~msk) == 16'h0)) else $error("interrupt line wrong");
	local_start_a: assert property (reg_wr && reg_addr == 8'h04 && reg_wdata[1]
		&& !local_action_request && !pcm_action_request && !local_req_ack_evt
		&& !local_req_fail_evt |=> local_action_request) else $error("local request not started");
	local_done_a: assert property (local_req_fail_evt || local_req_ack_evt
		|=> !local_action_request) else $error("local request not cleared");
	pcm_done_a: assert property (pcm_req_fail_evt || pcm_req_ack_evt
		|=> !pcm_action_request) else $error("pcm request not cleared");
	gp_report_a: assert property (gpbus_evt_report |-> $past(gpbus_evt))
		else $error("bus pin report without event");
	demux_gate_a: assert property (demux_burst_active |-> $past(demux_pin))
		else $error("burst active without demux pin");
endmodule : gcsr_monitor
bind gcsr_top gcsr_monitor u_gcsr_monitor (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
	.queue_evt, .local_req_fail_evt, .local_req_ack_evt, .pcm_req_fail_evt,
	.pcm_req_ack_evt, .gpbus_evt, .demux_pin, .gpbus_evt_report, .demux_burst_active,
	.local_action_request, .pcm_action_request, .event_status_q, .inta_n);
`default_nettype wire

// file: dv/gcsr_host.sv
// Host software model that drives the register port and pin settings.
`timescale 1ns/1ps
`default_nettype none
module gcsr_host (
	input  wire logic                clk,
	input  wire logic [31:0]         reg_rdata,
	output var gcsr_pkg::gcsr_addr_t reg_addr,
	output logic                     reg_wr,
	output logic                     reg_rd,
	output var gcsr_pkg::gcsr_word_t reg_wdata,
	output logic [15:0]              gpbus_direction,
	output logic [15:0]              gpbus_open_drain,
	output logic [15:0]              gpbus_data
);
	import gcsr_pkg::*;
	// Idle bus at time zero; all pins start as inputs.
	initial begin
		reg_addr = 8'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
		gpbus_direction = 16'h0;
		gpbus_open_drain = 16'h0;
		gpbus_data = 16'h0;
	end
	// Write held for n edges; idle address and data are inverted so stale use shows.
	task automatic wr(input gcsr_addr_t a, input gcsr_word_t d, input int n);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		repeat (n) @(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	// Read strobe for one edge; data is taken once it has settled.
	task automatic rd(input gcsr_addr_t a, output logic [31:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask : rd
	// Direction, open-drain and data settings, chosen per pin function.
	task automatic pins(input logic [15:0] dir, input logic [15:0] od, input logic [15:0] dat);
		@(negedge clk);
		gpbus_direction = dir;
		gpbus_open_drain = od;
		gpbus_data = dat;
	endtask : pins
endmodule : gcsr_host
`default_nettype wire

// file: dv/gcsr_top_tb.sv
// Self-checking bench for the global register block.
`timescale 1ns/1ps
`default_nettype none
module gcsr_top_tb;
	import gcsr_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	gcsr_addr_t  reg_addr;
	gcsr_word_t  reg_wdata;
	logic        reg_wr, reg_rd;
	logic [31:0] reg_rdata, v;
	logic [15:0] ev = 16'h0, gin = 16'h0, gdir, god, gdat, gout, goe, gbin, evq;
	logic        rsp = 1'b0, dmx = 1'b0, rate = 1'b0, sclk = 1'b0, sdo = 1'b0;
	logic [3:0]  scs = 4'h0, drq = 4'h0, dack;
	logic        sdi, rpt, tba, lct, dba, bos, lar, par, inta_n;
	int          err_total = 0, checked = 0, ticks = 0, tis = 0;
	gcsr_host u_gcsr_host (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.gpbus_direction(gdir), .gpbus_open_drain(god), .gpbus_data(gdat));
	gcsr_top u_gcsr_top (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.queue_evt(ev[15:8]), .tx_sync_async_evt(ev[5]), .rx_sync_async_evt(ev[4]),
		.local_req_fail_evt(ev[3]), .local_req_ack_evt(ev[2]), .pcm_req_fail_evt(ev[1]),
		.pcm_req_ack_evt(ev[0]), .gpbus_evt(ev[6]), .rx_frame_sync_pin(rsp),
		.demux_pin(dmx), .pcm_rate_2_or_4(rate), .gpbus_direction(gdir),
		.gpbus_open_drain(god), .gpbus_data(gdat), .gp_pin_in(gin), .gp_pin_out(gout),
		.gp_pin_oe(goe), .gpbus_in(gbin), .serial_clock(sclk), .serial_data_out(sdo),
		.serial_chip_select(scs), .serial_data_in(sdi), .dma_request(drq), .dma_ack(dack),
		.gpbus_evt_report(rpt), .terminal_bus_active(tba), .local_clk_tick(lct),
		.demux_burst_active(dba), .byte_order_select(bos), .local_action_request(lar),
		.pcm_action_request(par), .event_status_q(evq), .inta_n);
	// Clock at 100 MHz.
	always #5 clk = ~clk;
	// Counts divided clock ticks and cycles with the timer flag up.
	always @(posedge clk) begin
		ticks <= ticks + lct;
		tis <= tis + evq[6];
	end
	// Compares one result and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// One-cycle event pulse on the selected sources.
	task automatic pulse(input logic [15:0] p);
		@(negedge clk);
		ev = p;
		@(negedge clk);
		ev = 16'h0;
	endtask : pulse
	task automatic test_done;
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	// Cuts a hang short.
	initial begin
		#100000;
		err_total++;
		test_done();
	end
	// Main sequence of register accesses and pin checks.
	initial begin
		cyc(2);
		rst = 1'b0;
		u_gcsr_host.rd(8'h00, v); chk(v, 32'h0);
		u_gcsr_host.rd(8'h0c, v); chk(v, 32'hff7f);
		u_gcsr_host.rd(8'h04, v); chk(v, 32'h0);
		chk({goe, 15'h0, inta_n}, 32'h1);
		gin = 16'ha5c3;
		u_gcsr_host.pins(16'h00ff, 16'h000f, 16'h0005);
		cyc(3);
		chk({gbin, goe}, 32'ha5c3_00fa);
		chk(gout, 16'h0005);
		u_gcsr_host.wr(8'h10, 32'h1, 1);
		u_gcsr_host.rd(8'h10, v); chk(v, 32'h0);
		u_gcsr_host.wr(8'h00, 32'hffff_ffff, 1);
		u_gcsr_host.rd(8'h00, v); chk(v, 32'h1ff);
		chk({dba, tba, bos}, 3'b001);
		{dmx, rate, sclk, scs, drq, gin} = {3'b111, 4'b0101, 4'b1001, 16'h2006};
		u_gcsr_host.pins(16'hdff0, 16'h0, 16'h0);
		cyc(3);
		chk({dba, tba}, 2'b11);
		chk(gout & 16'hdff0, 16'h8a90);
		chk({gbin, goe}, 32'h0000_dff0);
		chk({sdi, dack}, 5'h16);
		for (int i = 0; i < 4; i++) begin
			u_gcsr_host.wr(8'h00, i << 2, 1);
			cyc(20);
			ticks = 0;
			cyc(32);
			chk(ticks, (i == 3) ? 2 : 32 >> i);
		end
		pulse(16'hff3f);
		u_gcsr_host.rd(8'h08, v); chk(v, 32'hff3f);
		chk(inta_n, 1'b1);
		u_gcsr_host.wr(8'h0c, 32'h0, 1); cyc(2); chk(inta_n, 1'b0);
		u_gcsr_host.wr(8'h08, 32'hff3f, 1); cyc(1);
		u_gcsr_host.rd(8'h08, v); chk({v[31:1], inta_n}, 32'h1);
		for (int i = 0; i < 2; i++) begin
			u_gcsr_host.wr(8'h00, i << 7, 1);
			pulse(16'h0040); chk(rpt, i);
		end
		u_gcsr_host.wr(8'h04, 32'h2, 1); chk({lar, par}, 2'b10);
		u_gcsr_host.wr(8'h04, 32'h1, 1); chk({lar, par}, 2'b10);
		pulse(16'h0004); chk({lar, par}, 2'b00);
		u_gcsr_host.wr(8'h04, 32'h1, 1); chk({lar, par}, 2'b01);
		pulse(16'h0002); chk({lar, par}, 2'b00);
		u_gcsr_host.rd(8'h08, v); chk(v, 32'h6);
		u_gcsr_host.wr(8'h00, 32'h0, 1);
		u_gcsr_host.wr(8'h04, 32'h0003_0010, 1);
		fork
			u_gcsr_host.wr(8'h08, 32'hffff, 60);
			begin
				cyc(5);
				tis = 0;
				cyc(50);
				chk(tis, 10);
			end
		join
		u_gcsr_host.wr(8'h04, 32'h0, 1);
		u_gcsr_host.wr(8'h08, 32'h40, 1);
		cyc(30);
		u_gcsr_host.rd(8'h08, v); chk(v, 32'h0);
		u_gcsr_host.wr(8'h00, 32'h100, 1);
		u_gcsr_host.wr(8'h04, 32'h10, 1);
		cyc(20);
		u_gcsr_host.rd(8'h08, v); chk(v, 32'h0);
		repeat (4) begin
			@(negedge clk) rsp = 1'b1;
			@(negedge clk) rsp = 1'b0;
		end
		cyc(3);
		u_gcsr_host.rd(8'h08, v); chk(v, 32'h40);
		test_done();
	end
endmodule : gcsr_top_tb
`default_nettype wire
